//--- design/mfid_decoder.sv
// Multi-function input decoder with APB register file
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mfid_params.svh"
module mfid_decoder #(
	parameter int NTERM = 6
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [NTERM-1:0] term_in,
	input  wire logic             fault_cause,
	input  wire logic             motor_stopped,
	input  wire logic             run_request,
	input  wire logic             prog_run_request,
	input  wire logic             speed_matched,
	output mfid_pkg::mfid_cmd_s   cmd,
	output logic                  output_enable,
	output logic                  ramp_stop,
	output logic                  coast_stop,
	output logic                  search_up,
	output logic                  search_down,
	output logic                  prog_restart,
	output logic                  freq_up,
	output logic                  freq_down,
	output logic [15:0]           count_value
);
	localparam int STEP_CYC = `MFID_STEP_MS * `MFID_CLK_KHZ;

	// Terminal count is fixed by the code register layout
	if (NTERM != 6) begin : g_bad_nterm
		$error("mfid_decoder supports six terminals only");
	end

	mfid_pkg::mfid_run_e state_reg, state_next;
	logic [31:0]      code_lo_reg, code_hi_reg;
	logic [7:0]       ctrl_reg;
	logic [7:0]       fault_code_reg;
	logic [15:0]      count_reg;
	logic             count_pulse;
	logic             inhibit_stop_reg;
	logic             pc_cancel_reg;
	logic             was_up_reg, was_dn_reg;
	logic [31:0]      rep_reg;
	logic [NTERM-1:0] lvl;
	mfid_pkg::mfid_code_t code [NTERM];
	logic [31:0]      act;

	// Terminal synchronisers, one per input
	for (genvar g = 0; g < NTERM; g++) begin : g_sync
		mfid_sync u_sync (
			.pclk    (pclk),
			.presetn (presetn),
			.din     (term_in[g]),
			.dout    (lvl[g])
		);
	end

	// Effective code per terminal after mode overrides
	wire [1:0] team_sel   = ctrl_reg[`MFID_CTRL_TEAM_LSB +: 2];
	wire       three_wire = ctrl_reg[`MFID_CTRL_3WIRE];
	wire [2:0] ramp_mode  = ctrl_reg[`MFID_CTRL_RMODE_LSB +: 3];
	wire       team_split = (team_sel == `MFID_TEAM_SPLIT);
	always_comb begin
		code[0] = code_lo_reg[4:0];
		code[1] = code_lo_reg[9:5];
		code[2] = code_lo_reg[14:10];
		code[3] = code_lo_reg[19:15];
		code[4] = code_hi_reg[4:0];
		code[5] = code_hi_reg[9:5];
		if (three_wire) code[0] = `MFID_FC_NONE;
		if (team_split) code[2] = `MFID_FC_NONE;
		for (int i = 0; i < NTERM; i++) begin
			if (code[i] > `MFID_FC_MAX) code[i] = `MFID_FC_NONE;
		end
	end

	// One activity bit per function code; code zero never lands anywhere
	always_comb begin
		act = 32'h0000_0000;
		for (int i = 0; i < NTERM; i++) begin
			if (lvl[i]) act[code[i]] = 1'b1;
		end
		act[0] = 1'b0;
	end

	// Level commands
	wire jog_ok  = act[`MFID_FC_JOG] && motor_stopped;
	wire blocked = act[`MFID_FC_BB_UP] || act[`MFID_FC_BB_DN];
	always_comb begin
		cmd               = '0;
		cmd.step_index    = act[4:1];
		cmd.ramp_set2     = act[`MFID_FC_RAMPSEL];
		cmd.ramp_hold     = act[`MFID_FC_INHIBIT];
		cmd.pid_bypass    = act[`MFID_FC_NOPID];
		cmd.force_ext_run = act[`MFID_FC_EXTRUN];
		cmd.linear_ramp   = act[`MFID_FC_LINRAMP] &&
			(ramp_mode >= 3'h1) && (ramp_mode <= 3'h4);
		cmd.jog_fwd       = act[`MFID_FC_JOGF];
		cmd.jog_rev       = act[`MFID_FC_JOGR];
		cmd.jog_key       = jog_ok;
		cmd.prog_pause    = act[`MFID_FC_PPAUSE];
		cmd.dc_brake      = act[`MFID_FC_DCBRAKE] &&
			(state_reg == mfid_pkg::MFID_RUN_ACTIVE);
		cmd.team_b        = team_split && lvl[2];
		// First matching override wins when several are held
		if (act[`MFID_FC_SRC_V])        cmd.freq_src = mfid_pkg::MFID_SRC_V;
		else if (act[`MFID_FC_SRC_I])   cmd.freq_src = mfid_pkg::MFID_SRC_I;
		else if (act[`MFID_FC_SRC_AUX]) cmd.freq_src = mfid_pkg::MFID_SRC_AUX;
		else                            cmd.freq_src = mfid_pkg::MFID_SRC_CFG;
	end

	// Run state: fault, base block and speed search
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			mfid_pkg::MFID_RUN_IDLE: begin
				if (act[`MFID_FC_EXTFLT]) state_next = mfid_pkg::MFID_RUN_FAULT;
				else if (blocked) state_next = mfid_pkg::MFID_RUN_BLOCK;
				else if (run_request && !act[`MFID_FC_RSTOP] && !inhibit_stop_reg)
					state_next = mfid_pkg::MFID_RUN_ACTIVE;
			end
			mfid_pkg::MFID_RUN_ACTIVE: begin
				if (act[`MFID_FC_EXTFLT]) state_next = mfid_pkg::MFID_RUN_FAULT;
				else if (blocked) state_next = mfid_pkg::MFID_RUN_BLOCK;
				else if (act[`MFID_FC_RSTOP] || !run_request)
					state_next = mfid_pkg::MFID_RUN_IDLE;
			end
			mfid_pkg::MFID_RUN_FAULT: begin
				// Reset only takes once the cause is gone
				if (act[`MFID_FC_RESET] && !fault_cause && !act[`MFID_FC_EXTFLT])
					state_next = mfid_pkg::MFID_RUN_IDLE;
			end
			mfid_pkg::MFID_RUN_BLOCK: begin
				if (act[`MFID_FC_EXTFLT]) state_next = mfid_pkg::MFID_RUN_FAULT;
				else if (!blocked) state_next = mfid_pkg::MFID_RUN_SEARCH;
			end
			mfid_pkg::MFID_RUN_SEARCH: begin
				if (act[`MFID_FC_EXTFLT]) state_next = mfid_pkg::MFID_RUN_FAULT;
				else if (blocked) state_next = mfid_pkg::MFID_RUN_BLOCK;
				else if (speed_matched) state_next = mfid_pkg::MFID_RUN_ACTIVE;
			end
			default: state_next = mfid_pkg::MFID_RUN_IDLE;
		endcase
	end

	// Search direction remembered from the block code
	logic search_dn_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) search_dn_reg <= 1'b0;
		else if (act[`MFID_FC_BB_DN]) search_dn_reg <= 1'b1;
		else if (act[`MFID_FC_BB_UP]) search_dn_reg <= 1'b0;
	end

	// State, fault log and latched ramp-stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg        <= mfid_pkg::MFID_RUN_IDLE;
			fault_code_reg   <= 8'h00;
			inhibit_stop_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_next == mfid_pkg::MFID_RUN_FAULT &&
				state_reg != mfid_pkg::MFID_RUN_FAULT)
				fault_code_reg <= `MFID_FAULT_CODE_EF;
			// Stay stopped after release until run drops and returns
			if (act[`MFID_FC_RSTOP]) inhibit_stop_reg <= 1'b1;
			else if (!run_request) inhibit_stop_reg <= 1'b0;
		end
	end

	assign output_enable = state_reg == mfid_pkg::MFID_RUN_ACTIVE ||
		state_reg == mfid_pkg::MFID_RUN_SEARCH;
	assign ramp_stop   = act[`MFID_FC_RSTOP] || inhibit_stop_reg;
	assign coast_stop  = state_reg == mfid_pkg::MFID_RUN_FAULT;
	assign search_up   = state_reg == mfid_pkg::MFID_RUN_SEARCH && !search_dn_reg;
	assign search_down = state_reg == mfid_pkg::MFID_RUN_SEARCH && search_dn_reg;

	// Program cancel: restart pulse on the next program run request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pc_cancel_reg <= 1'b0;
		else if (act[`MFID_FC_PCANCEL]) pc_cancel_reg <= 1'b1;
		else if (prog_run_request) pc_cancel_reg <= 1'b0;
	end
	assign prog_restart = pc_cancel_reg && prog_run_request &&
		!act[`MFID_FC_PCANCEL];

	// Up/down stepping: edge pulse then repeat while held
	wire up_only = act[`MFID_FC_UP] && !act[`MFID_FC_DOWN];
	wire dn_only = act[`MFID_FC_DOWN] && !act[`MFID_FC_UP];
	wire rep_hit = rep_reg == 32'(STEP_CYC - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			was_up_reg <= 1'b0;
			was_dn_reg <= 1'b0;
			rep_reg    <= 32'h0000_0000;
			freq_up    <= 1'b0;
			freq_down  <= 1'b0;
		end else begin
			was_up_reg <= up_only;
			was_dn_reg <= dn_only;
			if (!(up_only || dn_only) || rep_hit) rep_reg <= 32'h0000_0000;
			else rep_reg <= rep_reg + 32'h0000_0001;
			freq_up   <= up_only && (!was_up_reg || rep_hit);
			freq_down <= dn_only && (!was_dn_reg || rep_hit);
		end
	end

	// Counter held at zero while clear is active
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) count_reg <= 16'h0000;
		else if (act[`MFID_FC_CLRCNT]) count_reg <= 16'h0000;
		else if (count_pulse) count_reg <= count_reg + 16'h0001;
	end
	assign count_value = count_reg;

	// APB decode
	wire wr_en     = psel && penable && pwrite;
	wire hit_lo    = paddr == `MFID_OFF_CODE_LO;
	wire hit_hi    = paddr == `MFID_OFF_CODE_HI;
	wire hit_ctrl  = paddr == `MFID_OFF_CTRL;
	wire hit_stat  = paddr == `MFID_OFF_STATUS;
	wire hit_cmd   = paddr == `MFID_OFF_CMD;
	wire hit_cnt   = paddr == `MFID_OFF_COUNT;
	wire hit_flt   = paddr == `MFID_OFF_FAULT;
	wire mapped    = hit_lo || hit_hi || hit_ctrl || hit_stat ||
		hit_cmd || hit_cnt || hit_flt;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Writable registers; count increment is a software write to COUNT
	assign count_pulse = wr_en && hit_cnt && pwdata[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_lo_reg <= `MFID_CODE_LO_RST;
			code_hi_reg <= `MFID_CODE_HI_RST;
			ctrl_reg    <= 8'h00;
		end else begin
			if (wr_en && hit_lo) code_lo_reg <= {12'h000, pwdata[19:0]};
			if (wr_en && hit_hi) code_hi_reg <= {22'h000000, pwdata[9:0]};
			if (wr_en && hit_ctrl) ctrl_reg <= pwdata[7:0];
		end
	end

	// Read mux registered into prdata
	logic [31:0] rd_next;
	always_comb begin
		rd_next = 32'h0000_0000;
		if (hit_lo)   rd_next = code_lo_reg;
		if (hit_hi)   rd_next = code_hi_reg;
		if (hit_ctrl) rd_next = {24'h000000, ctrl_reg};
		if (hit_stat) rd_next = {23'h000000, freq_down, freq_up, search_down,
			search_up, coast_stop, ramp_stop, output_enable, 2'(lvl[1:0]) ^ 2'h0}
			| {26'h0, lvl} << 9;
		if (hit_cmd)  rd_next = {15'h0000, cmd};
		if (hit_cnt)  rd_next = {16'h0000, count_reg};
		if (hit_flt)  rd_next = {24'h000000, fault_code_reg};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) prdata <= rd_next;
	end
endmodule : mfid_decoder
`default_nettype wire

//--- design/mfid_params.svh
// Constants for the multi-function input decoder
`ifndef MFID_PARAMS_SVH
`define MFID_PARAMS_SVH

// APB register byte offsets
`define MFID_OFF_CODE_LO   12'h000
`define MFID_OFF_CODE_HI   12'h004
`define MFID_OFF_CTRL      12'h008
`define MFID_OFF_STATUS    12'h00c
`define MFID_OFF_CMD       12'h010
`define MFID_OFF_COUNT     12'h014
`define MFID_OFF_FAULT     12'h018

// Function codes
`define MFID_FC_NONE       5'h00
`define MFID_FC_STEP1      5'h01
`define MFID_FC_STEP4      5'h04
`define MFID_FC_RESET      5'h05
`define MFID_FC_CLRCNT     5'h06
`define MFID_FC_RAMPSEL    5'h07
`define MFID_FC_INHIBIT    5'h08
`define MFID_FC_SRC_V      5'h09
`define MFID_FC_SRC_I      5'h0a
`define MFID_FC_SRC_AUX    5'h0b
`define MFID_FC_RSTOP      5'h0c
`define MFID_FC_NOPID      5'h0d
`define MFID_FC_EXTFLT     5'h0e
`define MFID_FC_BB_UP      5'h0f
`define MFID_FC_BB_DN      5'h10
`define MFID_FC_EXTRUN     5'h11
`define MFID_FC_LINRAMP    5'h12
`define MFID_FC_JOGF       5'h13
`define MFID_FC_JOGR       5'h14
`define MFID_FC_JOG        5'h15
`define MFID_FC_PCANCEL    5'h16
`define MFID_FC_PPAUSE     5'h17
`define MFID_FC_UP         5'h18
`define MFID_FC_DOWN       5'h19
`define MFID_FC_DCBRAKE    5'h1a
`define MFID_FC_MAX        5'h1a

// Reset values of the code registers: terminals 1..6 = 1,2,3,4,5,14
`define MFID_CODE_LO_RST   32'h0002_0c41
`define MFID_CODE_HI_RST   32'h0000_01c5

// Control register fields
`define MFID_CTRL_TEAM_LSB 0
`define MFID_CTRL_3WIRE    2
`define MFID_CTRL_RMODE_LSB 3
`define MFID_TEAM_SPLIT    2'h2
`define MFID_FAULT_CODE_EF 8'h0e

// Time between repeated frequency steps while held
`define MFID_STEP_MS       10
`define MFID_CLK_KHZ       50000

`endif

//--- design/mfid_pkg.sv
// Types shared by the multi-function input decoder
package mfid_pkg;
	typedef logic [4:0] mfid_code_t;

	typedef enum logic [1:0] {
		MFID_SRC_CFG,
		MFID_SRC_V,
		MFID_SRC_I,
		MFID_SRC_AUX
	} mfid_src_e;

	typedef enum {
		MFID_RUN_IDLE,
		MFID_RUN_ACTIVE,
		MFID_RUN_FAULT,
		MFID_RUN_BLOCK,
		MFID_RUN_SEARCH
	} mfid_run_e;

	// Decoded commands handed to the drive core
	typedef struct packed {
		logic [3:0] step_index;
		logic       ramp_set2;
		logic       ramp_hold;
		mfid_src_e  freq_src;
		logic       pid_bypass;
		logic       force_ext_run;
		logic       linear_ramp;
		logic       jog_fwd;
		logic       jog_rev;
		logic       jog_key;
		logic       prog_pause;
		logic       dc_brake;
		logic       team_b;
	} mfid_cmd_s;
endpackage : mfid_pkg

//--- design/mfid_sync.sv
// Two-flop synchroniser for one terminal level
`timescale 1ns/1ns
`default_nettype none
module mfid_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);
	logic meta_reg;

	// First flop feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			dout     <= 1'b0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule : mfid_sync
`default_nettype wire

//--- verif/mfid_switches.sv
// Switch contacts wired to the input terminals
`timescale 1ns/1ns
`default_nettype none
module mfid_switches (
	input  wire logic       pclk,
	input  wire logic [5:0] closed,
	output logic      [5:0] term_in = 6'h00
);
	// Contacts move just after an edge, never on it
	always @(posedge pclk) begin
		term_in <= closed;
	end
endmodule : mfid_switches
`default_nettype wire

//--- verif/mfid_decoder_sva.sv
// Port assertions for the input decoder
`timescale 1ns/1ns
`default_nettype none
module mfid_decoder_sva (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [11:0]         paddr,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire mfid_pkg::mfid_cmd_s cmd,
	input wire logic                motor_stopped,
	input wire logic                output_enable,
	input wire logic                coast_stop,
	input wire logic                search_up,
	input wire logic                search_down,
	input wire logic                freq_up,
	input wire logic                freq_down
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Access phase of one transfer
	sequence access_s;
		psel && penable;
	endsequence
	sequence searching_s;
		search_up || search_down;
	endsequence
	ready_tied_a: assert property (access_s |-> pready)
		else $error("pready low in access phase");
	unmapped_err_a: assert property (access_s ##0 (paddr > 12'h018) |-> pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (access_s ##0 (paddr <= 12'h018 && paddr[1:0] == 2'b00)
		|-> !pslverr)
		else $error("error on mapped address");
	jog_stopped_a: assert property (cmd.jog_key |-> motor_stopped)
		else $error("jog while motor turns");
	brake_run_a: assert property (cmd.dc_brake |-> output_enable)
		else $error("brake while not running");
	coast_cut_a: assert property (coast_stop |-> !output_enable)
		else $error("output on while coasting");
	search_one_a: assert property (searching_s |-> output_enable && !(search_up && search_down))
		else $error("bad speed search state");
	step_pulse_a: assert property (freq_up || freq_down |=> !(freq_up || freq_down) [*8])
		else $error("frequency step not a single pulse");
	step_excl_a: assert property (!(freq_up && freq_down))
		else $error("up and down together");
endmodule : mfid_decoder_sva
`default_nettype wire

//--- verif/mfid_decoder_test.sv
// Self-checking bench for the input decoder
`timescale 1ns/1ns
`default_nettype none
module mfid_decoder_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, fault_cause = 1'b0, motor_stopped = 1'b0;
	logic [5:0]  closed = 6'h00, term_in;
	logic        output_enable, ramp_stop, coast_stop, search_up, search_down;
	logic        prog_restart, freq_up, freq_down;
	logic [15:0] count_value;
	logic        run_request = 1'b0, prog_run_request = 1'b0, speed_matched = 1'b0;
	mfid_pkg::mfid_cmd_s cmd, e;
	int          mismatches = 0, total_checks = 0, pulses = 0, n;
	logic [4:0]  codes [14] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0d,
		5'h11, 5'h12, 5'h13, 5'h14, 5'h17, 5'h1b, 5'h15};

	mfid_switches i_sw (.pclk(pclk), .closed(closed), .term_in(term_in));
	// Run, program and search inputs come from the scenarios
	mfid_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .term_in(term_in), .fault_cause(fault_cause),
		.motor_stopped(motor_stopped), .run_request(run_request),
		.prog_run_request(prog_run_request), .speed_matched(speed_matched), .cmd(cmd),
		.output_enable(output_enable),
		.ramp_stop(ramp_stop), .coast_stop(coast_stop), .search_up(search_up),
		.search_down(search_down), .prog_restart(prog_restart), .freq_up(freq_up),
		.freq_down(freq_down), .count_value(count_value));

	initial begin
		forever #10 pclk = ~pclk;
	end
	// Step pulses seen: an up step counts one, a down step 256
	always @(posedge pclk) begin
		if (freq_up === 1'b1) pulses <= pulses + 1;
		else if (freq_down === 1'b1) pulses <= pulses + 256;
	end

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	// Two sync flops plus the contact delay fit well inside eight edges
	task automatic press(input logic [5:0] c);
		closed <= c;
		repeat (8) @(posedge pclk);
	endtask : press

	task automatic cmd_is(input logic [3:0] s, input logic t);
		e = '0;
		e.step_index = s;
		e.team_b = t;
		check("cmd", {15'h0, e}, {15'h0, cmd});
	endtask : cmd_is

	function automatic mfid_pkg::mfid_cmd_s exp_cmd(input logic [4:0] c);
		mfid_pkg::mfid_cmd_s r;
		r = '0;
		case (c)
			5'h07: r.ramp_set2 = 1'b1;
			5'h08: r.ramp_hold = 1'b1;
			5'h09: r.freq_src = mfid_pkg::MFID_SRC_V;
			5'h0a: r.freq_src = mfid_pkg::MFID_SRC_I;
			5'h0b: r.freq_src = mfid_pkg::MFID_SRC_AUX;
			5'h0d: r.pid_bypass = 1'b1;
			5'h11: r.force_ext_run = 1'b1;
			5'h12: r.linear_ramp = 1'b1;
			5'h13: r.jog_fwd = 1'b1;
			5'h14: r.jog_rev = 1'b1;
			5'h15: r.jog_key = 1'b1;
			5'h17: r.prog_pause = 1'b1;
			default: r = '0;
		endcase
		return r;
	endfunction : exp_cmd

	task automatic test_regs();
		apb(1'b0, 12'h000, 32'h0);
		check("code_lo", 32'h0002_0c41, rd);
		apb(1'b0, 12'h004, 32'h0);
		check("code_hi", 32'h0000_01c5, rd);
		apb(1'b1, 12'h040, 32'hffff_ffff);
		check("pslverr", 32'h1, {31'h0, err});
		apb(1'b0, 12'h040, 32'h0);
		check("unmapped", 32'h0, rd);
		$display("test_regs done");
	endtask : test_regs

	task automatic test_steps();
		press(6'h0a);
		cmd_is(4'ha, 1'b0);
		apb(1'b1, 12'h008, 32'h2);
		press(6'h0f);
		cmd_is(4'hb, 1'b1);
		apb(1'b1, 12'h008, 32'h4);
		press(6'h0f);
		cmd_is(4'he, 1'b0);
		apb(1'b1, 12'h008, 32'h0);
		press(6'h00);
		$display("test_steps done");
	endtask : test_steps

	task automatic test_table();
		apb(1'b1, 12'h008, 32'h8);
		motor_stopped <= 1'b1;
		foreach (codes[i]) begin
			apb(1'b1, 12'h004, {22'h0, 5'h0e, codes[i]});
			press(6'h10);
			check("cmd", {15'h0, exp_cmd(codes[i])}, {15'h0, cmd});
		end
		motor_stopped <= 1'b0;
		press(6'h10);
		cmd_is(4'h0, 1'b0);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h004, {22'h0, 5'h0e, 5'h12});
		press(6'h10);
		cmd_is(4'h0, 1'b0);
		press(6'h00);
		$display("test_table done");
	endtask : test_table

	task automatic test_fault();
		apb(1'b1, 12'h004, 32'h0000_01c5);
		fault_cause <= 1'b1;
		press(6'h20);
		check("coast", 32'h1, {31'h0, coast_stop});
		apb(1'b0, 12'h018, 32'h0);
		check("fault code", 32'h0e, rd);
		press(6'h10);
		check("coast", 32'h1, {31'h0, coast_stop});
		fault_cause <= 1'b0;
		press(6'h00);
		press(6'h10);
		check("coast", 32'h0, {31'h0, coast_stop});
		press(6'h00);
		$display("test_fault done");
	endtask : test_fault

	// Flags: output enable, ramp stop, search up, search down, DC brake
	task automatic run_is(input logic [4:0] x);
		check("run flags", {27'h0, x},
			{27'h0, output_enable, ramp_stop, search_up, search_down, cmd.dc_brake});
	endtask : run_is

	// Terminals: 1 ramp stop, 2 block up, 3 block down, 4 clear, 5 brake, 6 cancel
	task automatic test_run();
		apb(1'b1, 12'h000, 32'h0003_41ec);
		apb(1'b1, 12'h004, 32'h0000_02da);
		run_request <= 1'b1;
		press(6'h00);
		run_is(5'h10);
		press(6'h10);
		run_is(5'h11);
		press(6'h01);
		run_is(5'h08);
		press(6'h10);
		run_is(5'h08);
		run_request <= 1'b0;
		press(6'h00);
		run_request <= 1'b1;
		press(6'h00);
		run_is(5'h10);
		press(6'h04);
		run_is(5'h00);
		press(6'h00);
		run_is(5'h12);
		speed_matched <= 1'b1;
		press(6'h00);
		run_is(5'h10);
		speed_matched <= 1'b0;
		press(6'h02);
		run_is(5'h00);
		press(6'h00);
		run_is(5'h14);
		speed_matched <= 1'b1;
		run_request <= 1'b0;
		press(6'h00);
		run_is(5'h00);
		speed_matched <= 1'b0;
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b0, 12'h014, 32'h0);
		check("count", 32'h2, rd);
		press(6'h08);
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b0, 12'h014, 32'h0);
		check("count", 32'h0, rd);
		check("count", 32'h0, {16'h0, count_value});
		press(6'h00);
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b0, 12'h014, 32'h0);
		check("count", 32'h1, {16'h0, count_value});
		press(6'h20);
		check("restart", 32'h0, {31'h0, prog_restart});
		press(6'h00);
		prog_run_request <= 1'b1;
		@(posedge pclk);
		check("restart", 32'h1, {31'h0, prog_restart});
		@(posedge pclk);
		check("restart", 32'h0, {31'h0, prog_restart});
		prog_run_request <= 1'b0;
		$display("test_run done");
	endtask : test_run

	task automatic test_updown();
		apb(1'b1, 12'h004, 32'h0000_0338);
		n = pulses;
		press(6'h10);
		check("pulses", 32'h1, 32'(pulses - n));
		press(6'h00);
		n = pulses;
		press(6'h20);
		check("pulses", 32'h100, 32'(pulses - n));
		press(6'h00);
		n = pulses;
		press(6'h30);
		check("pulses", 32'h0, 32'(pulses - n));
		$display("test_updown done");
	endtask : test_updown

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_steps();
		test_table();
		test_fault();
		test_run();
		test_updown();
		give_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		give_verdict();
	end
endmodule : mfid_decoder_test

bind mfid_decoder mfid_decoder_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .cmd(cmd),
	.motor_stopped(motor_stopped), .output_enable(output_enable), .coast_stop(coast_stop),
	.search_up(search_up), .search_down(search_down), .freq_up(freq_up),
	.freq_down(freq_down));
`default_nettype wire
